// *** include/cmsc_pkg.sv ***
// constants, types and the register map of the clock mode and stop controller
// assumes an apb slave at 40 MHz; analog parts are modelled as status inputs
package cmsc_pkg;
  localparam logic [7:0] CMSC_OFS_SYNTH = 8'h00;
  localparam logic [7:0] CMSC_OFS_REFDIV = 8'h04;
  localparam logic [7:0] CMSC_OFS_POSTDIV = 8'h08;
  localparam logic [7:0] CMSC_OFS_CLKSEL = 8'h0c;
  localparam logic [7:0] CMSC_OFS_OSC = 8'h10;
  localparam logic [7:0] CMSC_OFS_STATUS = 8'h14;
  localparam logic [7:0] CMSC_OFS_TRIM = 8'h18;
  localparam logic [7:0] CMSC_OFS_EVENT = 8'h1c;
  localparam logic [7:0] CMSC_OFS_STATE = 8'h20;
  // vco = 2 * 1 MHz * (mult + 1) = 64 MHz
  localparam logic [5:0] CMSC_SYNTH_RST = 6'h1f;
  localparam logic [4:0] CMSC_POSTDIV_RST = 5'h03;
  localparam logic [3:0] CMSC_REFDIV_RST = 4'h0;
  // clock select field positions
  localparam int CMSC_B_PLL_CLOCK_SELECT = 0;
  localparam int CMSC_B_PSTOP = 1;
  localparam int CMSC_B_WDSEL = 2;
  localparam int CMSC_B_RTISEL = 3;
  // status and event bits
  localparam int CMSC_B_UP = 0;
  localparam int CMSC_B_LOCK = 1;
  localparam int CMSC_B_LVD = 2;
  localparam int CMSC_B_LOCKEV = 0;
  localparam int CMSC_B_LVIEV = 1;
  localparam int CMSC_B_PORF = 2;
  localparam int CMSC_B_RSTF = 3;
  localparam int CMSC_CLK_MHZ = 40;
  localparam int CMSC_OSCILLATOR_UP_FLAG_US = 100;
  localparam int CMSC_OSCILLATOR_UP_FLAG_CYC = CMSC_OSCILLATOR_UP_FLAG_US * CMSC_CLK_MHZ;
  localparam int CMSC_SW_GAP = 2;
  typedef enum logic [1:0] {
    CMSC_MODE_RUN, CMSC_MODE_FULL_STOP, CMSC_MODE_PSEUDO_STOP
  } cmsc_mode_t;
endpackage

// *** hdl/cmsc_clk_switch.sv ***
// glitch free two-input clock multiplexer, modelled as enables in pclk domain
// assumes both sources are presented as one-cycle enable pulses on pclk
`timescale 1ns/1ps
module cmsc_clk_switch
  import cmsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sel_pll,
  input wire logic pll_en,
  input wire logic osc_en,
  input wire logic halt,
  output logic clk_en,
  output logic sel_pll_now
);
  typedef struct packed {
    logic pll_on;
    logic osc_on;
    logic en;
  } cmsc_sw_t;
  cmsc_sw_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    // break before make: a source drops only at its own pulse, the other waits
    if (s_r.pll_on && !sel_pll && pll_en) begin
      s_nxt.pll_on = 1'b0;
    end
    if (s_r.osc_on && sel_pll && osc_en) begin
      s_nxt.osc_on = 1'b0;
    end
    if (!s_r.pll_on && !s_r.osc_on) begin
      if (sel_pll && pll_en) begin
        s_nxt.pll_on = 1'b1;
      end else if (!sel_pll && osc_en) begin
        s_nxt.osc_on = 1'b1;
      end
    end
    s_nxt.en = !halt && ((s_r.pll_on && pll_en) || (s_r.osc_on && osc_en));
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{pll_on: 1'b1, osc_on: 1'b0, en: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign clk_en = s_r.en;
  assign sel_pll_now = s_r.pll_on;
endmodule

// *** hdl/cmsc_top.sv ***
// clock mode and stop controller with apb register access
// pll lock and voltage detectors arrive as synchronous levels; oscillator startup is counted internally
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module cmsc_top
  import cmsc_pkg::*;
#(
  parameter int OSCILLATOR_UP_FLAG_CYC = CMSC_OSCILLATOR_UP_FLAG_CYC,
  parameter int BUS_DIV = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_instr,
  input wire logic wait_instr,
  input wire logic wakeup,
  input wire logic pll_lock,
  input wire logic lv_detect,
  input wire logic lv_reset,
  input wire logic por,
  input wire logic illegal_access,
  input wire logic watchdog_timeout,
  input wire logic clock_monitor_fail,
  input wire logic ext_reset_n,
  input wire logic [9:0] flash_trim,
  input wire logic flash_trim_valid,
  output logic system_reset,
  output logic lock_irq,
  output logic lvi_irq,
  output logic pll_enable,
  output logic irc_enable,
  output logic osc_enable_out,
  output logic regulator_full_power,
  output logic api_available,
  output logic pll_ref_external,
  output logic [5:0] vco_mult,
  output logic [3:0] reference_divider,
  output logic [4:0] post_divider,
  output logic [9:0] irc_trim,
  output logic bus_clk_en,
  output logic core_clk_run,
  output logic wd_clk_run,
  output logic rti_clk_run
);
  // refused at elaboration: the divider counter is eight bits wide
  if (OSCILLATOR_UP_FLAG_CYC < 1 || BUS_DIV < 2 || BUS_DIV > 255) begin : g_bad_param
    $error("cmsc_top: bad parameter");
  end
  typedef struct packed {
    logic [5:0] synth;
    logic [3:0] refdiv;
    logic [4:0] postdiv;
    logic pll_clock_select;
    logic pseudo_stop_enable;
    logic watchdog_clock_source_select;
    logic rti_clock_source_select;
    logic oscillator_enable;
    logic watchdog_enable;
    logic rti_enable;
    logic [9:0] trim;
    logic trim_written;
    logic lock_ev;
    logic lvi_ev;
    logic por_flag;
    logic rst_flag;
    logic lock_q;
    logic lvd_q;
    cmsc_mode_t mode;
    logic [31:0] up_cnt;
    logic oscillator_up_flag;
    logic [7:0] div_cnt;
    logic pll_tick;
    logic osc_tick;
    logic [31:0] rdata;
    logic sysrst;
  } cmsc_st_t;
  cmsc_st_t r_r, r_nxt;
  logic wr, rd, hit, sw_sel, sw_en;
  logic pseudo;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pseudo = r_r.pseudo_stop_enable && r_r.oscillator_enable;
  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      CMSC_OFS_SYNTH, CMSC_OFS_REFDIV, CMSC_OFS_POSTDIV, CMSC_OFS_CLKSEL,
      CMSC_OFS_OSC, CMSC_OFS_STATUS, CMSC_OFS_TRIM, CMSC_OFS_EVENT,
      CMSC_OFS_STATE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  always_comb begin
    r_nxt = r_r;
    r_nxt.lock_q = pll_lock;
    r_nxt.lvd_q = lv_detect;
    // reset sources are combined here; set over clear on flags
    r_nxt.sysrst = por || lv_reset || illegal_access || watchdog_timeout
                   || clock_monitor_fail || !ext_reset_n;
    if (!r_r.trim_written && flash_trim_valid) begin
      r_nxt.trim = flash_trim;
    end
    // oscillator startup counter, restarted whenever the oscillator stops
    if (!r_r.oscillator_enable || r_r.mode == CMSC_MODE_FULL_STOP) begin
      r_nxt.up_cnt = '0;
      r_nxt.oscillator_up_flag = 1'b0;
    end else if (r_r.up_cnt >= 32'(OSCILLATOR_UP_FLAG_CYC - 1)) begin
      r_nxt.oscillator_up_flag = 1'b1;
    end else begin
      r_nxt.up_cnt = r_r.up_cnt + 32'h1;
    end
    // stand-in source clocks as enables derived from pclk
    r_nxt.div_cnt = (r_r.div_cnt >= 8'(BUS_DIV - 1)) ? 8'h00 : r_r.div_cnt + 8'h01;
    r_nxt.pll_tick = (r_r.div_cnt == 8'h00);
    r_nxt.osc_tick = r_r.oscillator_up_flag && (r_r.div_cnt == 8'(BUS_DIV / 2));
    // apb writes
    if (wr) begin
      unique case (paddr)
        CMSC_OFS_SYNTH: r_nxt.synth = pwdata[5:0];
        CMSC_OFS_REFDIV: r_nxt.refdiv = pwdata[3:0];
        CMSC_OFS_POSTDIV: r_nxt.postdiv = pwdata[4:0];
        CMSC_OFS_CLKSEL: begin
          r_nxt.pll_clock_select = pwdata[CMSC_B_PLL_CLOCK_SELECT];
          r_nxt.pseudo_stop_enable = pwdata[CMSC_B_PSTOP];
          r_nxt.watchdog_clock_source_select = pwdata[CMSC_B_WDSEL];
          r_nxt.rti_clock_source_select = pwdata[CMSC_B_RTISEL];
        end
        CMSC_OFS_OSC: begin
          r_nxt.oscillator_enable = pwdata[0];
          r_nxt.watchdog_enable = pwdata[1];
          r_nxt.rti_enable = pwdata[2];
        end
        CMSC_OFS_TRIM: begin
          r_nxt.trim = pwdata[9:0];
          r_nxt.trim_written = 1'b1;
        end
        CMSC_OFS_EVENT: begin
          // write one to clear
          if (pwdata[CMSC_B_LOCKEV]) r_nxt.lock_ev = 1'b0;
          if (pwdata[CMSC_B_LVIEV]) r_nxt.lvi_ev = 1'b0;
          if (pwdata[CMSC_B_PORF]) r_nxt.por_flag = 1'b0;
          if (pwdata[CMSC_B_RSTF]) r_nxt.rst_flag = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // events set after the clear so that a coincident set wins
    if (pll_lock != r_r.lock_q) r_nxt.lock_ev = 1'b1;
    if (lv_detect && !r_r.lvd_q) r_nxt.lvi_ev = 1'b1;
    if (por) r_nxt.por_flag = 1'b1;
    if (r_nxt.sysrst) r_nxt.rst_flag = 1'b1;
    // mode sequencing; wait instruction leaves clocking untouched
    unique case (r_r.mode)
      CMSC_MODE_RUN: begin
        if (stop_instr) begin
          r_nxt.mode = pseudo ? CMSC_MODE_PSEUDO_STOP : CMSC_MODE_FULL_STOP;
        end
      end
      CMSC_MODE_FULL_STOP: begin
        if (wakeup) begin
          r_nxt.mode = CMSC_MODE_RUN;
          r_nxt.pll_clock_select = 1'b1;
          r_nxt.watchdog_clock_source_select = 1'b0;
          r_nxt.rti_clock_source_select = 1'b0;
        end
      end
      CMSC_MODE_PSEUDO_STOP: begin
        if (wakeup) r_nxt.mode = CMSC_MODE_RUN;
      end
    endcase
    unique case (paddr)
      CMSC_OFS_SYNTH: r_nxt.rdata = {26'h0, r_r.synth};
      CMSC_OFS_REFDIV: r_nxt.rdata = {28'h0, r_r.refdiv};
      CMSC_OFS_POSTDIV: r_nxt.rdata = {27'h0, r_r.postdiv};
      CMSC_OFS_CLKSEL: r_nxt.rdata = {28'h0, r_r.rti_clock_source_select,
          r_r.watchdog_clock_source_select, r_r.pseudo_stop_enable, r_r.pll_clock_select};
      CMSC_OFS_OSC: r_nxt.rdata = {29'h0, r_r.rti_enable, r_r.watchdog_enable,
          r_r.oscillator_enable};
      CMSC_OFS_STATUS: r_nxt.rdata = {29'h0, r_r.lvd_q, r_r.lock_q, r_r.oscillator_up_flag};
      CMSC_OFS_TRIM: r_nxt.rdata = {22'h0, r_r.trim};
      CMSC_OFS_EVENT: r_nxt.rdata = {28'h0, r_r.rst_flag, r_r.por_flag, r_r.lvi_ev,
          r_r.lock_ev};
      CMSC_OFS_STATE: r_nxt.rdata = {30'h0, r_r.mode};
      default: r_nxt.rdata = 32'h0;
    endcase
    if (!rd) r_nxt.rdata = r_r.rdata;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '{synth: CMSC_SYNTH_RST, refdiv: CMSC_REFDIV_RST,
               postdiv: CMSC_POSTDIV_RST,
               pll_clock_select: 1'b1,
               mode: CMSC_MODE_RUN, por_flag: 1'b1, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end
  // bypass keeps the pll running as a spike filter reference
  assign sw_sel = r_r.pll_clock_select || !r_r.oscillator_up_flag;
  cmsc_clk_switch u_sw (
    .pclk(pclk),
    .presetn(presetn),
    .sel_pll(sw_sel),
    .pll_en(r_r.pll_tick),
    .osc_en(r_r.osc_tick),
    // next mode, so no bus pulse slips out in the first stop cycle
    .halt(r_nxt.mode != CMSC_MODE_RUN),
    .clk_en(sw_en),
    .sel_pll_now()
  );
  assign bus_clk_en = sw_en;
  assign core_clk_run = (r_r.mode == CMSC_MODE_RUN);
  assign pll_enable = (r_r.mode == CMSC_MODE_RUN);
  assign irc_enable = (r_r.mode == CMSC_MODE_RUN);
  assign regulator_full_power = (r_r.mode == CMSC_MODE_RUN);
  assign api_available = 1'b1;
  assign osc_enable_out = r_r.oscillator_enable && (r_r.mode != CMSC_MODE_FULL_STOP);
  assign pll_ref_external = r_r.oscillator_enable && r_r.oscillator_up_flag;
  assign wd_clk_run = r_r.watchdog_enable && (r_r.mode != CMSC_MODE_FULL_STOP);
  assign rti_clk_run = r_r.rti_enable && (r_r.mode != CMSC_MODE_FULL_STOP);
  assign vco_mult = r_r.synth;
  assign reference_divider = r_r.refdiv;
  assign post_divider = r_r.postdiv;
  assign irc_trim = r_r.trim;
  assign system_reset = r_r.sysrst;
  assign lock_irq = r_r.lock_ev;
  assign lvi_irq = r_r.lvi_ev;
  assign prdata = r_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
endmodule

// *** sim/cmsc_top_monitor.sv ***
// port assertions for the clock mode and stop controller
// assumes one pclk domain and the reset figures of cmsc_pkg
`timescale 1ns/1ps
module cmsc_top_monitor
  import cmsc_pkg::*;
#(
  parameter int OSCILLATOR_UP_FLAG_CYC = CMSC_OSCILLATOR_UP_FLAG_CYC,
  parameter int BUS_DIV = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stop_instr,
  input wire logic wakeup,
  input wire logic pll_lock,
  input wire logic lv_detect,
  input wire logic lv_reset,
  input wire logic por,
  input wire logic illegal_access,
  input wire logic watchdog_timeout,
  input wire logic clock_monitor_fail,
  input wire logic ext_reset_n,
  input wire logic system_reset,
  input wire logic lock_irq,
  input wire logic lvi_irq,
  input wire logic pll_enable,
  input wire logic irc_enable,
  input wire logic regulator_full_power,
  input wire logic [5:0] vco_mult,
  input wire logic [4:0] post_divider,
  input wire logic bus_clk_en,
  input wire logic core_clk_run
);
  int gap_r;
  // saturating gap counter, so a long stop cannot wrap it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      gap_r <= BUS_DIV;
    else if (bus_clk_en)
      gap_r <= 1;
    else if (gap_r < 64)
      gap_r <= gap_r + 1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_pll_setup:
    assert property (!$past(presetn) |-> vco_mult == CMSC_SYNTH_RST
      && post_divider == CMSC_POSTDIV_RST) else $error("pll setup wrong after reset");
  a_run_clocks_on:
    assert property (core_clk_run |-> pll_enable && irc_enable && regulator_full_power)
      else $error("run mode without pll, irc or full regulator");
  a_stop_entry_off:
    assert property (stop_instr && core_clk_run && !wakeup |=> !core_clk_run && !pll_enable
      && !irc_enable && !regulator_full_power) else $error("stop did not halt clocks");
  a_stop_bus_quiet:
    assert property (!core_clk_run |-> !bus_clk_en) else $error("bus clock in stop");
  a_stop_by_instr:
    assert property ($fell(core_clk_run) |-> $past(stop_instr)) else $error("stop without instr");
  a_reset_sources:
    assert property (por || lv_reset || illegal_access || watchdog_timeout
      || clock_monitor_fail || !ext_reset_n |=> system_reset) else $error("reset not raised");
  a_lock_change_irq:
    assert property ($changed(pll_lock) |=> lock_irq) else $error("lock change not flagged");
  a_lvi_rise_irq:
    assert property ($rose(lv_detect) |=> lvi_irq) else $error("low voltage not flagged");
  a_bus_pulse_gap:
    assert property (bus_clk_en |-> gap_r >= BUS_DIV) else $error("bus clock pulse too early");
  cover property (stop_instr && core_clk_run);
  cover property ($changed(pll_lock));
  cover property (system_reset);
endmodule
bind cmsc_top cmsc_top_monitor #(.OSCILLATOR_UP_FLAG_CYC(OSCILLATOR_UP_FLAG_CYC), .BUS_DIV(BUS_DIV)) mon_inst (.*);

// *** sim/cmsc_cpu_model.sv ***
// cpu and crystal side: stop instruction, wake-up and startup wait
// assumes osc_enable_out high means the crystal is powered
`timescale 1ns/1ps
module cmsc_cpu_model #(
  parameter int OSCILLATOR_UP_FLAG_CYC = 8
) (
  input wire logic pclk,
  input wire logic osc_enable_out,
  output logic stop_instr,
  output logic wakeup
);
  int run_cnt = 0;
  initial begin
    stop_instr = 1'h0;
    wakeup = 1'h0;
  end
  always @(posedge pclk) run_cnt <= osc_enable_out ? run_cnt + 1 : 0;
  task automatic enter_stop(input bit pseudo);
    int i;
    // a pseudo stop before startup would leave the crystal half started
    for (i = 0; i < 100 && pseudo && run_cnt <= OSCILLATOR_UP_FLAG_CYC; i++) @(posedge pclk);
    if (i == 100) tb_top.tmo();
    stop_instr <= 1'h1;
    @(posedge pclk);
    stop_instr <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic leave_stop();
    wakeup <= 1'h1;
    @(posedge pclk);
    wakeup <= 1'h0;
    @(posedge pclk);
  endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench: apb master, register model, stop and event scenarios
// assumes cmsc_cpu_model as cpu side and a shortened oscillator startup
`timescale 1ns/1ps
module tb_top;
  import cmsc_pkg::*;
  localparam int UP = 8;
  localparam int DIV = 5;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, wait_instr = '0;
  logic pll_lock = '0, lv_detect = '0, flash_trim_valid = '0, pready, pslverr, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [9:0] flash_trim = '0, irc_trim;
  logic [5:0] src = '0, vco_mult;
  logic [3:0] reference_divider;
  logic [4:0] post_divider;
  logic stop_instr, wakeup, system_reset, lock_irq, lvi_irq, pll_enable, irc_enable;
  logic osc_enable_out, regulator_full_power, api_available, pll_ref_external;
  logic bus_clk_en, core_clk_run, wd_clk_run, rti_clk_run;
  wire lv_reset, por, illegal_access, watchdog_timeout, clock_monitor_fail, ext_reset_n;
  int bad_count = 0, n_checks = 0, i, j, t;
  int mdl [5] = '{32'h1f, 0, 3, 1, 0};
  assign {lv_reset, por, illegal_access, watchdog_timeout, clock_monitor_fail} = src[4:0];
  assign ext_reset_n = !src[5];
  cmsc_top #(.OSCILLATOR_UP_FLAG_CYC(UP), .BUS_DIV(DIV)) cmsc_top_inst (.*);
  cmsc_cpu_model #(.OSCILLATOR_UP_FLAG_CYC(UP)) cmsc_cpu_model_inst (.*);
  initial forever #12.5 pclk = ~pclk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tmo();
    bad_count++;
    tally_and_finish();
  endtask
  initial begin
    #500000;
    tmo();
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (k == 20) tmo();
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, '0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  initial begin
    void'($urandom(50));
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    for (j = 0; j < 4; j++) rd(8'(j * 4), mdl[j]);
    rd(CMSC_OFS_STATE, 0);
    chk("pll_ref_external", 0, pll_ref_external);
    apb(1'h0, 8'h40, '0);
    chk("pslverr", 1, err);
    chk("unmapped", 0, q);
    // one bus pulse per divider period on the default pll source
    j = 0;
    repeat (5 * DIV) begin
      @(negedge pclk);
      if (bus_clk_en === 1'h1) j++;
    end
    chk("bus pulses", 5, j);
    @(posedge pclk);
    $display("test defaults finished");
    for (i = 0; i < 3; i++) begin
      mdl[0] = $urandom % 64;
      mdl[1] = $urandom % 16;
      mdl[2] = $urandom % 32;
      for (j = 0; j < 3; j++) apb(1'h1, 8'(j * 4), mdl[j]);
      for (j = 0; j < 3; j++) rd(8'(j * 4), mdl[j]);
      chk("dividers", {mdl[0][5:0], mdl[1][3:0], mdl[2][4:0]},
        {vco_mult, reference_divider, post_divider});
    end
    apb(1'h1, CMSC_OFS_OSC, 32'h7);
    q = '0;
    for (i = 0; i < 40 && q[0] !== 1'h1; i++) apb(1'h0, CMSC_OFS_STATUS, '0);
    chk("osc_up", 1, q[CMSC_B_UP]);
    chk("pll_ref_external", 1, pll_ref_external);
    apb(1'h1, CMSC_OFS_CLKSEL, '0);
    chk("pll_enable", 1, pll_enable);
    wait_instr <= 1'h1;
    @(posedge pclk);
    wait_instr <= 1'h0;
    @(negedge pclk);
    chk("run", 7, {core_clk_run, irc_enable, regulator_full_power});
    @(posedge pclk);
    $display("test bypass finished");
    // t 0 is pseudo stop with every select but pll_clock_select set, t 1 full stop
    for (t = 0; t < 2; t++) begin
      mdl[3] = t ? 32'hc : 32'he;
      apb(1'h1, CMSC_OFS_CLKSEL, mdl[3]);
      cmsc_cpu_model_inst.enter_stop(!t);
      rd(CMSC_OFS_STATE, t ? 1 : 2);
      q = {24'h0, osc_enable_out, wd_clk_run, rti_clk_run, core_clk_run, pll_enable,
           irc_enable, regulator_full_power, api_available};
      chk("stop pins", t ? 32'h01 : 32'he1, q);
      cmsc_cpu_model_inst.leave_stop();
      mdl[3] = t ? 1 : mdl[3];
      rd(CMSC_OFS_CLKSEL, mdl[3]);
    end
    $display("test stop finished");
    for (i = 0; i < 6; i++) begin
      src <= 6'h1 << i;
      @(posedge pclk);
      src <= '0;
      @(negedge pclk);
      chk("system_reset", 1, system_reset);
      @(posedge pclk);
    end
    for (i = 0; i < 2; i++) begin
      pll_lock <= !i;
      repeat (2) @(posedge pclk);
      apb(1'h0, CMSC_OFS_EVENT, '0);
      chk("lock event", 1, q[CMSC_B_LOCKEV]);
      apb(1'h1, CMSC_OFS_EVENT, 32'h1);
      apb(1'h0, CMSC_OFS_EVENT, '0);
      chk("lock cleared", 0, q[CMSC_B_LOCKEV]);
    end
    lv_detect <= 1'h1;
    repeat (2) @(posedge pclk);
    chk("lvi_irq", 1, lvi_irq);
    t = $urandom % 1024;
    flash_trim <= t[9:0];
    flash_trim_valid <= 1'h1;
    @(posedge pclk);
    flash_trim_valid <= 1'h0;
    @(negedge pclk);
    chk("flash trim", t, irc_trim);
    @(posedge pclk);
    apb(1'h1, CMSC_OFS_TRIM, ~t);
    chk("sw trim", ~t & 32'h3ff, irc_trim);
    $display("test events finished");
    tally_and_finish();
  end
endmodule
